// [scd_map.svh]
// Constants for the synchronous clock divider
`ifndef SCD_MAP_SVH
`define SCD_MAP_SVH

`define SCD_DIV_WIDTH     3
`define SCD_DIV_RESET     3'h0
`define SCD_ARM_WIDTH     2
`define SCD_ARM_RESET     2'h0
`define SCD_ARM_LAST      2'h2
`define SCD_SYNC_STAGES   3
`define SCD_HALF_BIT      0
`define SCD_QUARTER_BIT   1
`define SCD_EIGHTH_BIT    2

`endif

// [scd_pkg.sv]
// Types for the synchronous clock divider
package scd_pkg;

    typedef enum logic [1:0] {
        SCD_HELD = 2'b00,
        SCD_ARM  = 2'b01,
        SCD_RUN  = 2'b10
    } scd_state_t;

    typedef logic [2:0] scd_count_t;

endpackage

// [scd_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps

module scd_pin_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Pin and filtered level
    input  wire logic pinIn,
    output logic      level
);

    logic stage1;
    logic stage2;
    logic stage3;
    logic next_level;

    // Level moves only once stages two and three agree
    always_comb begin
        next_level = level;
        if (stage2 == stage3) begin
            next_level = stage3;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            stage1 <= RESET_LEVEL;
            stage2 <= RESET_LEVEL;
            stage3 <= RESET_LEVEL;
            level  <= RESET_LEVEL;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end

endmodule

// [scd_divider.sv]
// Synchronous divide-by-2/4/8 clock divider with freeze and reset
//
// Notes on behaviour
// - Reset released with clock low: half-rate output first toggles on third following rise.
// - Asserted freeze stops the stages at the next falling input edge.
// - While frozen every stage holds its state on any edge.
// - Freeze released: counting resumes from the next falling edge onward.
// - Resume steps from held state to next, keeping output phase.
`timescale 1ns/100ps
`include "scd_map.svh"

module scd_divider (
    // System clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Divider pins
    input  wire logic inputClock,
    input  wire logic enableN,
    input  wire logic divider_sync_reset,
    // Divided outputs
    output logic      half_rate_out,
    output logic      quarter_rate_out,
    output logic      eighth_rate_out
);
    import scd_pkg::*;

    // Synchronised pin levels
    logic                      clockLevel;
    logic                      enableNLevel;
    logic                      resetLevel;

    // Input clock edge detection
    logic                      clockPrev;
    logic                      next_clockPrev;
    logic                      riseSeen;
    logic                      fallSeen;

    // Freeze flop
    logic                      running;
    logic                      next_running;

    // Reset release sequencing
    scd_state_t                state;
    scd_state_t                next_state;
    logic [`SCD_ARM_WIDTH-1:0] armCount;
    logic [`SCD_ARM_WIDTH-1:0] next_armCount;
    logic                      armDone;

    // Divider stages
    scd_count_t                divCount;
    scd_count_t                next_divCount;
    logic                      advance;
    logic [`SCD_DIV_WIDTH-1:0] toggle;

    // Output flops
    logic                      next_half;
    logic                      next_quarter;
    logic                      next_eighth;

    // Pin synchronisers
    scd_pin_sync #(.RESET_LEVEL(1'b0)) clockSync (
        .clock (clock),
        .reset (reset),
        .pinIn (inputClock),
        .level (clockLevel)
    );

    scd_pin_sync #(.RESET_LEVEL(1'b0)) enableSync (
        .clock (clock),
        .reset (reset),
        .pinIn (enableN),
        .level (enableNLevel)
    );

    scd_pin_sync #(.RESET_LEVEL(1'b1)) resetSync (
        .clock (clock),
        .reset (reset),
        .pinIn (divider_sync_reset),
        .level (resetLevel)
    );

    // Input clock edges
    assign riseSeen = clockLevel & ~clockPrev;
    assign fallSeen = ~clockLevel & clockPrev;

    always_comb begin
        next_clockPrev = clockLevel;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            clockPrev <= 1'b0;
        end else begin
            clockPrev <= next_clockPrev;
        end
    end

    // Freeze flop, sampled on falling input edges only
    always_comb begin
        next_running = running;
        if (resetLevel) begin
            next_running = 1'b1;
        end else if (fallSeen) begin
            next_running = ~enableNLevel;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            running <= 1'b1;
        end else begin
            running <= next_running;
        end
    end

    // Third counted rise after release ends the arming phase
    assign armDone = riseSeen && (armCount == `SCD_ARM_LAST);

    // Reset release sequencing
    always_comb begin
        next_state    = state;
        next_armCount = armCount;
        unique case (state)
            SCD_HELD: begin
                next_armCount = `SCD_ARM_RESET;
                if (!resetLevel) begin
                    next_state = SCD_ARM;
                end
            end
            SCD_ARM: begin
                if (riseSeen) begin
                    next_armCount = armCount + 2'h1;
                end
                if (armDone) begin
                    next_state = SCD_RUN;
                end
            end
            SCD_RUN: begin
                next_armCount = armCount;
            end
            default: begin
                next_state = SCD_HELD;
            end
        endcase
        if (resetLevel) begin
            next_state    = SCD_HELD;
            next_armCount = `SCD_ARM_RESET;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state    <= SCD_HELD;
            armCount <= `SCD_ARM_RESET;
        end else begin
            state    <= next_state;
            armCount <= next_armCount;
        end
    end

    // Stages advance on a counted rise only while running
    always_comb begin
        advance = 1'b0;
        unique case (state)
            SCD_HELD: begin
                advance = 1'b0;
            end
            SCD_ARM: begin
                advance = armDone && running;
            end
            SCD_RUN: begin
                // Frozen stages keep their value
                advance = riseSeen && running;
            end
            default: begin
                advance = 1'b0;
            end
        endcase
    end

    // Each stage toggles once all lower stages are high
    always_comb begin
        toggle[`SCD_HALF_BIT]    = advance;
        toggle[`SCD_QUARTER_BIT] = advance && divCount[`SCD_HALF_BIT];
        toggle[`SCD_EIGHTH_BIT]  = advance && divCount[`SCD_HALF_BIT]
                                   && divCount[`SCD_QUARTER_BIT];
    end

    // Held state steps to the next count, phase kept
    always_comb begin
        next_divCount = divCount ^ toggle;
        if (resetLevel) begin
            next_divCount = `SCD_DIV_RESET;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            divCount <= `SCD_DIV_RESET;
        end else begin
            divCount <= next_divCount;
        end
    end

    // Output flops mirror the stage flops, edges aligned
    always_comb begin
        next_half    = next_divCount[`SCD_HALF_BIT];
        next_quarter = next_divCount[`SCD_QUARTER_BIT];
        next_eighth  = next_divCount[`SCD_EIGHTH_BIT];
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            half_rate_out    <= 1'b0;
            quarter_rate_out <= 1'b0;
            eighth_rate_out  <= 1'b0;
        end else begin
            half_rate_out    <= next_half;
            quarter_rate_out <= next_quarter;
            eighth_rate_out  <= next_eighth;
        end
    end

endmodule

// [scd_divider_asserts.sv]
// Assertions for the clock divider
`timescale 1ns/100ps
module scd_divider_asserts (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Watched pins
    input wire logic enableN,
    input wire logic divider_sync_reset,
    input wire logic half_rate_out,
    input wire logic quarter_rate_out,
    input wire logic eighth_rate_out
);
    logic [4:0] frz;
    logic [4:0] next_frz;
    wire  [2:0] q = {eighth_rate_out, quarter_rate_out, half_rate_out};
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Cycles with freeze held
    always_comb next_frz = !enableN ? 5'h00 : frz + 5'(frz != 5'h1f);
    always_ff @(posedge clock) frz <= reset ? 5'h00 : next_frz;
    AST_RST: assert property (disable iff (1'b0) reset |=> q == 3'h0)
        else $error("reset left outputs set");
    AST_CLR: assert property (divider_sync_reset [*8] |-> q == 3'h0)
        else $error("stages not cleared");
    AST_Q4: assert property ($rose(q[1]) |-> $fell(q[0]))
        else $error("quarter rise not aligned");
    AST_Q8: assert property ($rose(q[2]) |->
        $fell(q[1]) && $fell(q[0])) else $error("eighth rise not aligned");
    AST_STEP: assert property ($rose(q[0]) |-> $stable(q[2:1]))
        else $error("upper stages moved");
    AST_FRZ: assert property (disable iff (reset || divider_sync_reset)
        frz > 5'h14 |-> $stable(q)) else $error("outputs moved when frozen");
    cover property (frz == 5'h1f);
    cover property ($rose(q[2]));
    cover property (divider_sync_reset [*8]);
endmodule
bind scd_divider scd_divider_asserts i_chk (.clock, .reset, .enableN,
    .divider_sync_reset, .half_rate_out, .quarter_rate_out,
    .eighth_rate_out);

// [scd_clk_src.sv]
// Free-running source of the clock to be divided
`timescale 1ns/100ps
module scd_clk_src #(
    parameter time HALF = 40ns
) (
    // Source clock
    output logic inputClock
);
    initial begin
        inputClock = 1'h0;
        #13;
        forever #(HALF) inputClock = ~inputClock;
    end
endmodule

// [scd_divider_tb.sv]
// Self-checking bench for the clock divider
`timescale 1ns/100ps
module scd_divider_tb;
    logic       clock = 1'h0;
    logic       reset = 1'h1;
    logic       inputClock;
    logic       enableN = 1'h0;
    logic       divider_sync_reset = 1'h1;
    logic [2:0] q;
    logic [2:0] exp;
    logic       was;
    bit         frzNow;
    int         ign;
    int         n_fail = 0;
    int         comparisons = 0;
    int         seed = 32'h98a4_bcd0;
    always #2.5 clock = ~clock;
    scd_clk_src i_src (.inputClock(inputClock));
    scd_divider i_dut (.clock(clock), .reset(reset), .inputClock(inputClock),
        .enableN(enableN), .divider_sync_reset(divider_sync_reset),
        .half_rate_out(q[0]), .quarter_rate_out(q[1]),
        .eighth_rate_out(q[2]));
    function automatic logic [2:0] nxt(logic [2:0] c, bit adv);
        return adv ? c + 3'h1 : c;
    endfunction
    task automatic close_out();
        $display("failures %0d of %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic bad(string s);
        n_fail++;
        $display("ERROR %0t: %s", $time, s);
    endtask
    task automatic check(logic [2:0] e);
        comparisons++;
        if (q !== e) bad("divided outputs differ");
    endtask
    task automatic waitEdge(logic lvl);
        int k;
        k = 0;
        was = inputClock;
        while (!(inputClock === lvl && was !== lvl)) begin
            was = inputClock;
            @(posedge clock);
            if (++k > 40) begin
                bad("no input clock edge");
                close_out();
            end
        end
    endtask
    // One input rise, then freeze choice for the next fall
    task automatic step(bit f);
        waitEdge(1'h1);
        exp = nxt(exp, ign == 0 && !frzNow);
        if (ign > 0) ign--;
        enableN <= f;
        frzNow = f;
        repeat (6) @(posedge clock);
        check(exp);
    endtask
    // Divider reset, released while the input clock is low
    task automatic restart();
        divider_sync_reset <= 1'h1;
        enableN <= 1'h0;
        repeat (10) @(posedge clock);
        check(3'h0);
        waitEdge(1'h0);
        divider_sync_reset <= 1'h0;
        exp = 3'h0;
        ign = 2;
        frzNow = 1'b0;
    endtask
    initial begin
        repeat (12) @(posedge clock);
        reset <= 1'h0;
        for (int r = 0; r < 2; r++) begin
            restart();
            for (int i = 0; i < 3; i++) step(1'h0);
            for (int i = 0; i < 60; i++) step($random(seed) % 3 == 0);
        end
        close_out();
    end
endmodule
